// ---- verilog/slpclk_defs.svh ----
// Offsets, field positions and reset values of the sleep and clock control block
`ifndef SLPCLK_DEFS_SVH
`define SLPCLK_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define SLPCLK_SLEEP_OFFS   8'hbe
`define SLPCLK_CLKCTL_OFFS  8'hc6
`define SLPCLK_PWRCTL_OFFS  8'h87
`define SLPCLK_IRQSTAT_OFFS 8'hc0
`define SLPCLK_IRQMASK_OFFS 8'hc1

// ************************************************************
// Sleep mode control fields
// ************************************************************
`define SLPCLK_CALDIS_BIT   7
`define SLPCLK_XSTB_BIT     6
`define SLPCLK_HSTB_BIT     5
`define SLPCLK_CAUSE_HI     4
`define SLPCLK_CAUSE_LO     3
`define SLPCLK_PD_BIT       2
`define SLPCLK_MODE_HI      1
`define SLPCLK_MODE_LO      0

// ************************************************************
// Other fields
// ************************************************************
`define SLPCLK_CLKSEL_BIT   0
`define SLPCLK_IDLE_BIT     0
`define SLPCLK_EV_XSTB      0
`define SLPCLK_EV_HSTB      1
`define SLPCLK_EV_WAKE      2
`define SLPCLK_SYNC_CRYSTAL_OSCILLATOR    0
`define SLPCLK_SYNC_HFRC    1

// ************************************************************
// Reset values
// ************************************************************
`define SLPCLK_CALDIS_RST   1'b0
`define SLPCLK_PD_RST       1'b1
`define SLPCLK_MODE_RST     2'h0
`define SLPCLK_CAUSE_RST    2'h0
`define SLPCLK_CLKSEL_RST   1'b1
`define SLPCLK_MASK_RST     3'h0

`endif

// ---- verilog/slpclk_pkg.sv ----
// Types shared by the sleep and clock control block
package slpclk_pkg;

	typedef enum logic [1:0] {
		SLPCLK_PM_ACTIVE = 2'b01,
		SLPCLK_PM_ASLEEP = 2'b10
	} slpclk_pm_state_t;

	typedef enum logic [1:0] {
		SLPCLK_MODE_ACTIVE = 2'h0,
		SLPCLK_MODE_ONE    = 2'h1,
		SLPCLK_MODE_TWO    = 2'h2,
		SLPCLK_MODE_THREE  = 2'h3
	} slpclk_mode_t;

	typedef enum logic [1:0] {
		SLPCLK_CAUSE_POR  = 2'h0,
		SLPCLK_CAUSE_EXT  = 2'h1,
		SLPCLK_CAUSE_WDOG = 2'h2
	} slpclk_cause_t;

endpackage

// ---- verilog/slpclk_sync.sv ----
// Two-stage synchroniser for the oscillator stability flags
`timescale 1ns/100ps
module slpclk_sync
	import slpclk_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	input  wire logic [1:0] din,
	output logic      [1:0] dout
);

	logic [1:0] stage1_ff;
	logic [1:0] stage2_ff;

	// ************************************************************
	// Sync stages
	// ************************************************************
	// First stage feeds only the second one
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stage1_ff <= 2'h0;
			stage2_ff <= 2'h0;
		end else if (clk_en) begin
			stage1_ff <= din;
			stage2_ff <= stage1_ff;
		end
	end

	assign dout = stage2_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	AST_SYNC_TWO_STAGE: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		rst_b && clk_en ##1 clk_en |=> dout == $past(din, 2)
	) else $error("sync output is not the input two cycles back");

endmodule

// ---- verilog/slpclk_ctrl.sv ----
// Sleep mode, oscillator and system clock source control
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "slpclk_defs.svh"
module slpclk_ctrl
	import slpclk_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       crystal_oscillator_stable_raw,
	input  wire logic       hfrc_stable_raw,
	input  wire logic [1:0] rst_cause_in,
	input  wire logic       lf_cal_busy,
	input  wire logic       wake_port_irq,
	input  wire logic       wake_sleep_timer,
	input  wire logic       cpu_irq_any,
	output logic            sysclk_source_select,
	output logic            crystal_oscillator_powerdown,
	output logic            hfrc_powerdown,
	output logic            lf_cal_enable,
	output logic [1:0]      power_mode_now,
	output logic            cpu_halted,
	output logic            irq
);

	slpclk_pm_state_t pm_state_ff;
	logic       lf_rc_cal_disable_ff;
	logic       hf_osc_powerdown_ff;
	logic       pd_pend_ff;
	logic       pd_pend_val_ff;
	logic [1:0] mode_ff;
	logic [1:0] entered_mode_ff;
	logic [1:0] rst_cause_ff;
	logic       cause_taken_ff;
	logic       clk_req_ff;
	logic       sysclk_sel_ff;
	logic       crystal_oscillator_pd_ff;
	logic       hfrc_pd_ff;
	logic       lf_cal_en_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_mask_ff;
	logic       irq_ff;
	logic [7:0] rdata_ff;
	logic [1:0] stb_prev_ff;
	logic [1:0] stb_sync;
	logic       crystal_stable_flag;
	logic       hf_rc_stable_flag;
	logic       wr_sleep;
	logic       wr_idle;
	logic       wake;
	logic       hf_off;
	logic       deep_mode;
	logic [2:0] nxt_irq_stat;
	logic [7:0] nxt_rdata;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
		hit = (addr == offs);
	endfunction

	slpclk_sync u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.din     ({hfrc_stable_raw, crystal_oscillator_stable_raw}),
		.dout    (stb_sync)
	);

	assign crystal_stable_flag = stb_sync[`SLPCLK_SYNC_CRYSTAL_OSCILLATOR];
	assign hf_rc_stable_flag   = stb_sync[`SLPCLK_SYNC_HFRC];
	assign wr_sleep  = reg_wr && hit(reg_addr, `SLPCLK_SLEEP_OFFS);
	assign wr_idle   = reg_wr && hit(reg_addr, `SLPCLK_PWRCTL_OFFS) && reg_wdata[`SLPCLK_IDLE_BIT];
	// Idle in mode 0 only halts the core, so any interrupt wakes it
	assign wake      = wake_port_irq || wake_sleep_timer
		|| (cpu_irq_any && entered_mode_ff == SLPCLK_MODE_ACTIVE);
	assign hf_off    = (pm_state_ff == SLPCLK_PM_ASLEEP) && (entered_mode_ff != SLPCLK_MODE_ACTIVE);
	assign deep_mode = (entered_mode_ff == SLPCLK_MODE_TWO) || (entered_mode_ff == SLPCLK_MODE_THREE);

	// ************************************************************
	// Power mode sequencing
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pm_state_ff     <= SLPCLK_PM_ACTIVE;
			entered_mode_ff <= `SLPCLK_MODE_RST;
		end else if (clk_en) begin
			case (pm_state_ff)
				SLPCLK_PM_ACTIVE: begin
					if (wr_idle) begin
						pm_state_ff     <= SLPCLK_PM_ASLEEP;
						entered_mode_ff <= mode_ff;
					end
				end
				SLPCLK_PM_ASLEEP: begin
					if (wake) begin
						pm_state_ff     <= SLPCLK_PM_ACTIVE;
						entered_mode_ff <= SLPCLK_MODE_ACTIVE;
					end
				end
				default: begin
					pm_state_ff <= SLPCLK_PM_ACTIVE;
				end
			endcase
		end
	end

	// Mode field, cleared by any wake
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_ff <= `SLPCLK_MODE_RST;
		end else if (clk_en) begin
			if (pm_state_ff == SLPCLK_PM_ASLEEP && wake) begin
				mode_ff <= SLPCLK_MODE_ACTIVE;
			end else if (wr_sleep) begin
				mode_ff <= reg_wdata[`SLPCLK_MODE_HI:`SLPCLK_MODE_LO];
			end
		end
	end

	// ************************************************************
	// Calibration disable
	// ************************************************************
	// Not retained through the deep modes, so it leaves them at reset value
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lf_rc_cal_disable_ff <= `SLPCLK_CALDIS_RST;
		end else if (clk_en) begin
			if (pm_state_ff == SLPCLK_PM_ASLEEP && wake && deep_mode) begin
				lf_rc_cal_disable_ff <= `SLPCLK_CALDIS_RST;
			end else if (wr_sleep) begin
				lf_rc_cal_disable_ff <= reg_wdata[`SLPCLK_CALDIS_BIT];
			end
		end
	end

	// Calibration runs in active mode on a stable crystal
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lf_cal_en_ff <= 1'b0;
		end else if (clk_en) begin
			lf_cal_en_ff <= !(lf_rc_cal_disable_ff && sysclk_sel_ff)
				&& crystal_stable_flag && !hf_off;
		end
	end

	// ************************************************************
	// Oscillator power-down
	// ************************************************************
	// A write during calibration is parked and applied when it ends
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hf_osc_powerdown_ff <= `SLPCLK_PD_RST;
			pd_pend_ff          <= 1'b0;
			pd_pend_val_ff      <= `SLPCLK_PD_RST;
		end else if (clk_en) begin
			if (wr_sleep && lf_cal_busy) begin
				pd_pend_ff     <= 1'b1;
				pd_pend_val_ff <= reg_wdata[`SLPCLK_PD_BIT];
			end else if (wr_sleep) begin
				hf_osc_powerdown_ff <= reg_wdata[`SLPCLK_PD_BIT];
				pd_pend_ff          <= 1'b0;
			end else if (pd_pend_ff && !lf_cal_busy) begin
				hf_osc_powerdown_ff <= pd_pend_val_ff;
				pd_pend_ff          <= 1'b0;
			end
		end
	end

	// Sleep modes 1..3 stop both HF oscillators
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			crystal_oscillator_pd_ff <= 1'b1;
			hfrc_pd_ff <= 1'b0;
		end else if (clk_en) begin
			crystal_oscillator_pd_ff <= hf_off || (hf_osc_powerdown_ff && sysclk_sel_ff);
			hfrc_pd_ff <= hf_off || (hf_osc_powerdown_ff && !sysclk_sel_ff);
		end
	end

	// ************************************************************
	// System clock source
	// ************************************************************
	// Switch waits for the target to be stable; a glitch-free mux outside follows
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clk_req_ff    <= `SLPCLK_CLKSEL_RST;
			sysclk_sel_ff <= `SLPCLK_CLKSEL_RST;
		end else if (clk_en) begin
			if (reg_wr && hit(reg_addr, `SLPCLK_CLKCTL_OFFS)) begin
				clk_req_ff <= reg_wdata[`SLPCLK_CLKSEL_BIT];
			end
			if (clk_req_ff && hf_rc_stable_flag) begin
				sysclk_sel_ff <= 1'b1;
			end else if (!clk_req_ff && crystal_stable_flag) begin
				sysclk_sel_ff <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Reset cause
	// ************************************************************
	// Caught after release since a port may not feed an async reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_cause_ff   <= `SLPCLK_CAUSE_RST;
			cause_taken_ff <= 1'b0;
		end else if (clk_en && !cause_taken_ff) begin
			rst_cause_ff   <= rst_cause_in;
			cause_taken_ff <= 1'b1;
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (reg_rd && hit(reg_addr, `SLPCLK_IRQSTAT_OFFS)) begin
			nxt_irq_stat = 3'h0;
		end
		// Set wins over the read clear
		nxt_irq_stat[`SLPCLK_EV_XSTB] = nxt_irq_stat[`SLPCLK_EV_XSTB]
			|| (crystal_stable_flag && !stb_prev_ff[`SLPCLK_SYNC_CRYSTAL_OSCILLATOR]);
		nxt_irq_stat[`SLPCLK_EV_HSTB] = nxt_irq_stat[`SLPCLK_EV_HSTB]
			|| (hf_rc_stable_flag && !stb_prev_ff[`SLPCLK_SYNC_HFRC]);
		nxt_irq_stat[`SLPCLK_EV_WAKE] = nxt_irq_stat[`SLPCLK_EV_WAKE]
			|| (pm_state_ff == SLPCLK_PM_ASLEEP && wake);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat_ff <= 3'h0;
			irq_mask_ff <= `SLPCLK_MASK_RST;
			stb_prev_ff <= 2'h0;
			irq_ff      <= 1'b0;
		end else if (clk_en) begin
			irq_stat_ff <= nxt_irq_stat;
			stb_prev_ff <= stb_sync;
			irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
			if (reg_wr && hit(reg_addr, `SLPCLK_IRQMASK_OFFS)) begin
				irq_mask_ff <= reg_wdata[2:0];
			end
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_comb begin
		nxt_rdata = 8'h00;
		if (hit(reg_addr, `SLPCLK_SLEEP_OFFS)) begin
			nxt_rdata[`SLPCLK_CALDIS_BIT]                   = lf_rc_cal_disable_ff;
			nxt_rdata[`SLPCLK_XSTB_BIT]                     = crystal_stable_flag;
			nxt_rdata[`SLPCLK_HSTB_BIT]                     = hf_rc_stable_flag;
			nxt_rdata[`SLPCLK_CAUSE_HI:`SLPCLK_CAUSE_LO]    = rst_cause_ff;
			nxt_rdata[`SLPCLK_PD_BIT]                       = hf_osc_powerdown_ff;
			nxt_rdata[`SLPCLK_MODE_HI:`SLPCLK_MODE_LO]      = mode_ff;
		end else if (hit(reg_addr, `SLPCLK_CLKCTL_OFFS)) begin
			nxt_rdata[`SLPCLK_CLKSEL_BIT] = sysclk_sel_ff;
		end else if (hit(reg_addr, `SLPCLK_IRQSTAT_OFFS)) begin
			nxt_rdata[2:0] = irq_stat_ff;
		end else if (hit(reg_addr, `SLPCLK_IRQMASK_OFFS)) begin
			nxt_rdata[2:0] = irq_mask_ff;
		end
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 8'h00;
		end else if (clk_en) begin
			rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
		end
	end

	assign reg_rdata            = rdata_ff;
	assign sysclk_source_select = sysclk_sel_ff;
	assign crystal_oscillator_powerdown       = crystal_oscillator_pd_ff;
	assign hfrc_powerdown       = hfrc_pd_ff;
	assign lf_cal_enable        = lf_cal_en_ff;
	assign power_mode_now       = entered_mode_ff;
	assign cpu_halted           = pm_state_ff[1];
	assign irq                  = irq_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	AST_CALDIS_WRITE: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && wr_sleep && pm_state_ff == SLPCLK_PM_ACTIVE
		|=> lf_rc_cal_disable_ff == $past(reg_wdata[7])
	) else $error("calibration disable bit not written");

	AST_CALDIS_GATED: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !sysclk_sel_ff && crystal_stable_flag && !hf_off |=> lf_cal_en_ff
	) else $error("calibration stopped while crystal clocks the system");

	AST_CALDIS_DEEP_WAKE: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && pm_state_ff == SLPCLK_PM_ASLEEP && wake && deep_mode
		|=> !lf_rc_cal_disable_ff && pm_state_ff == SLPCLK_PM_ACTIVE
	) else $error("calibration disable kept through deep sleep");

	AST_XSTB_READ: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && reg_rd && reg_addr == `SLPCLK_SLEEP_OFFS
		|=> reg_rdata[6] == $past(stb_sync[0]) && reg_rdata[5] == $past(stb_sync[1])
	) else $error("stability flags wrong on read");

	AST_CAUSE_LAST: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		rst_b && clk_en && !cause_taken_ff |=> rst_cause_ff == $past(rst_cause_in) ##1 $stable(rst_cause_ff)
	) else $error("reset cause not captured once");

	AST_PD_UNSELECTED: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && hf_osc_powerdown_ff && !hf_off |=> (crystal_oscillator_pd_ff != hfrc_pd_ff)
	) else $error("power-down did not stop exactly one oscillator");

	AST_PD_DEFER: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && wr_sleep && lf_cal_busy
		|=> pd_pend_ff && hf_osc_powerdown_ff == $past(hf_osc_powerdown_ff)
	) else $error("power-down changed during calibration");

	AST_IDLE_ONLY: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && pm_state_ff == SLPCLK_PM_ACTIVE && !wr_idle |=> pm_state_ff == SLPCLK_PM_ACTIVE
	) else $error("sleep entered without idle write");

	AST_WAKE_CLEAR: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && pm_state_ff == SLPCLK_PM_ASLEEP && wake |=> mode_ff == 2'h0 && !cpu_halted
	) else $error("wake did not clear mode");

	AST_CLK_SWITCH: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		clk_en && !clk_req_ff && crystal_stable_flag |=> !sysclk_source_select
	) else $error("clock source did not follow request");

	COV_DEEP_SLEEP: cover property (@(posedge clk_sys) disable iff (!rst_b)
		clk_en && wr_idle && mode_ff == 2'h3 ##[1:50] wake);
	COV_PD_DEFER: cover property (@(posedge clk_sys) disable iff (!rst_b)
		pd_pend_ff ##[1:50] !pd_pend_ff);
	COV_CLK_CRYSTAL_OSCILLATOR: cover property (@(posedge clk_sys) disable iff (!rst_b)
		sysclk_sel_ff ##1 !sysclk_sel_ff);
	COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(irq_ff));

endmodule

// ---- bench/sleep_clock_control_bench.sv ----
// Self-checking bench for the sleep and clock control block
`timescale 1ns/100ps
`include "slpclk_defs.svh"
module sleep_clock_control_bench
	import slpclk_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	logic       clk_sys;
	logic       rst_b;
	logic       clk_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       crystal_oscillator_stable_raw;
	logic       hfrc_stable_raw;
	logic [1:0] rst_cause_in;
	logic       lf_cal_busy;
	logic       wake_port_irq;
	logic       wake_sleep_timer;
	logic       cpu_irq_any;
	logic       sysclk_source_select;
	logic       crystal_oscillator_powerdown;
	logic       hfrc_powerdown;
	logic       lf_cal_enable;
	logic [1:0] power_mode_now;
	logic       cpu_halted;
	logic       irq;
	int         err_count;
	int         num_checks;
	int         cycle_count;
	logic [7:0] rd_val;

	typedef struct {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp_rd;
		logic       exp_xpd;
		logic       exp_hpd;
	} slpclk_row_t;

	// Crystal flag low, HF RC stable, cause power-on, HF RC selected
	slpclk_row_t rows [8] = '{
		'{8'hbe, 8'h00, 8'h20, 1'b0, 1'b0},
		'{8'hbe, 8'hff, 8'ha7, 1'b1, 1'b0},
		'{8'hbe, 8'h5a, 8'h22, 1'b0, 1'b0},
		'{8'hbe, 8'h01, 8'h21, 1'b0, 1'b0},
		'{8'hbe, 8'h04, 8'h24, 1'b1, 1'b0},
		'{8'hc1, 8'h05, 8'h05, 1'b1, 1'b0},
		'{8'h10, 8'hff, 8'h00, 1'b1, 1'b0},
		'{8'hc6, 8'h01, 8'h01, 1'b1, 1'b0}
	};

	slpclk_ctrl i_slpclk_ctrl (
		.clk_sys              (clk_sys),
		.rst_b                (rst_b),
		.clk_en               (clk_en),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.crystal_oscillator_stable_raw      (crystal_oscillator_stable_raw),
		.hfrc_stable_raw      (hfrc_stable_raw),
		.rst_cause_in         (rst_cause_in),
		.lf_cal_busy          (lf_cal_busy),
		.wake_port_irq        (wake_port_irq),
		.wake_sleep_timer     (wake_sleep_timer),
		.cpu_irq_any          (cpu_irq_any),
		.sysclk_source_select (sysclk_source_select),
		.crystal_oscillator_powerdown       (crystal_oscillator_powerdown),
		.hfrc_powerdown       (hfrc_powerdown),
		.lf_cal_enable        (lf_cal_enable),
		.power_mode_now       (power_mode_now),
		.cpu_halted           (cpu_halted),
		.irq                  (irq)
	);

	// ************************************************************
	// Clock and timeout
	// ************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Whole run is about 1770 cycles
	always @(posedge clk_sys) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == 4000) begin
			err_count++;
			summarize();
		end
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic read_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		logic [7:0] d;
		reg_read(a, d);
		chk_byte(d & m, exp);
	endtask

	task automatic do_reset(input logic [1:0] cause);
		@(posedge clk_sys);
		rst_cause_in <= cause;
		rst_b        <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b        <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic pulse(input int which);
		@(posedge clk_sys);
		if (which == 0) wake_port_irq <= 1'b1;
		else if (which == 1) wake_sleep_timer <= 1'b1;
		else cpu_irq_any <= 1'b1;
		@(posedge clk_sys);
		wake_port_irq    <= 1'b0;
		wake_sleep_timer <= 1'b0;
		cpu_irq_any      <= 1'b0;
		#1;
	endtask

	// Switch may take a few edges while the target's flag settles
	task automatic wait_sel(input logic v);
		int n;
		n = 0;
		while (sysclk_source_select !== v && n < 10) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk_bit(sysclk_source_select, v);
	endtask

	task automatic summarize();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst_b = 1'b0; clk_en = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
		reg_wr = 1'b0; reg_rd = 1'b0; crystal_oscillator_stable_raw = 1'b0; hfrc_stable_raw = 1'b1;
		rst_cause_in = SLPCLK_CAUSE_POR; lf_cal_busy = 1'b0; wake_port_irq = 1'b0;
		wake_sleep_timer = 1'b0; cpu_irq_any = 1'b0; err_count = 0; num_checks = 0;
		cycle_count = 0;
		repeat (2) @(posedge clk_sys);
		#1 chk_bit(sysclk_source_select, 1'b1);
		chk_bit(crystal_oscillator_powerdown, 1'b1);
		chk_bit(lf_cal_enable, 1'b0);
		chk_bit(cpu_halted, 1'b0);
		@(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		read_chk(8'hbe, 8'hff, 8'h24);
		read_chk(8'hc0, 8'hff, 8'h02);
		foreach (rows[i]) begin
			reg_write(rows[i].addr, rows[i].wdata);
			read_chk(rows[i].addr, 8'hff, rows[i].exp_rd);
			chk_bit(crystal_oscillator_powerdown, rows[i].exp_xpd);
			chk_bit(hfrc_powerdown, rows[i].exp_hpd);
		end
		read_chk(8'h87, 8'hff, 8'h00);
		// Power-down change parked behind a calibration
		lf_cal_busy <= 1'b1;
		reg_write(8'hbe, 8'h00);
		read_chk(8'hbe, 8'hff, 8'h24);
		lf_cal_busy <= 1'b0;
		repeat (2) @(posedge clk_sys);
		read_chk(8'hbe, 8'hff, 8'h20);
		reg_write(8'hbe, 8'h04);
		// Crystal start, calibration gating and source switch
		crystal_oscillator_stable_raw <= 1'b1;
		repeat (3) @(posedge clk_sys);
		read_chk(8'hbe, 8'hff, 8'h64);
		chk_bit(irq, 1'b1);
		read_chk(8'hc0, 8'h01, 8'h01);
		#1 chk_bit(irq, 1'b0);
		repeat (1600) @(posedge clk_sys);
		chk_bit(lf_cal_enable, 1'b1);
		reg_write(8'hbe, 8'h84);
		repeat (2) @(posedge clk_sys);
		#1 chk_bit(lf_cal_enable, 1'b0);
		reg_write(8'hc6, 8'h00);
		wait_sel(1'b0);
		repeat (2) @(posedge clk_sys);
		#1 chk_bit(lf_cal_enable, 1'b1);
		chk_bit(crystal_oscillator_powerdown, 1'b0);
		chk_bit(hfrc_powerdown, 1'b1);
		read_chk(8'hc6, 8'h01, 8'h00);
		reg_write(8'hbe, 8'h80);
		repeat (2) @(posedge clk_sys);
		#1 chk_bit(hfrc_powerdown, 1'b0);
		reg_write(8'hc6, 8'h01);
		wait_sel(1'b1);
		reg_write(8'hc1, 8'h04);
		// Sleep modes one to three, wake by port or timer
		for (int m = 1; m <= 3; m++) begin
			reg_write(8'hbe, 8'h84 | m[7:0]);
			#1 chk_bit(cpu_halted, 1'b0);
			reg_write(8'h87, 8'h01);
			#1 chk_bit(cpu_halted, 1'b1);
			chk_byte({6'h00, power_mode_now}, m[7:0]);
			@(posedge clk_sys);
			#1 chk_bit(crystal_oscillator_powerdown, 1'b1);
			chk_bit(hfrc_powerdown, 1'b1);
			chk_bit(lf_cal_enable, 1'b0);
			pulse(m == 3 ? 0 : 1);
			chk_bit(cpu_halted, 1'b0);
			chk_byte({6'h00, power_mode_now}, 8'h00);
			@(posedge clk_sys);
			#1 chk_bit(irq, 1'b1);
			read_chk(8'hbe, 8'hff, m == 1 ? 8'he4 : 8'h64);
			read_chk(8'hc0, 8'h04, 8'h04);
			#1 chk_bit(irq, 1'b0);
		end
		// Mode zero idle, masked wake event
		reg_write(8'hc1, 8'h00);
		reg_write(8'hbe, 8'h04);
		reg_write(8'h87, 8'h01);
		@(posedge clk_sys);
		#1 chk_bit(cpu_halted, 1'b1);
		chk_bit(hfrc_powerdown, 1'b0);
		pulse(2);
		chk_bit(cpu_halted, 1'b0);
		repeat (2) @(posedge clk_sys);
		#1 chk_bit(irq, 1'b0);
		read_chk(8'hc0, 8'h04, 8'h04);
		// Write with the clock enable low must leave the register untouched
		clk_en <= 1'b0;
		reg_write(8'hbe, 8'h83);
		clk_en <= 1'b1;
		read_chk(8'hbe, 8'hff, 8'h64);
		// Reset causes, then two resets in succession
		do_reset(SLPCLK_CAUSE_EXT);
		read_chk(8'hbe, 8'hff, 8'h6c);
		do_reset(SLPCLK_CAUSE_WDOG);
		read_chk(8'hbe, 8'hff, 8'h74);
		do_reset(SLPCLK_CAUSE_POR);
		read_chk(8'hbe, 8'hff, 8'h64);
		do_reset(SLPCLK_CAUSE_EXT);
		do_reset(SLPCLK_CAUSE_WDOG);
		read_chk(8'hbe, 8'h18, 8'h10);
		summarize();
	end
endmodule
